// >>> hw/agl_top.sv
// Audio gain, offset, ramp, limiter and input level control parameter block
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module agl_top
   import agl_pkg::*;
#(
   parameter int RAMP_UNIT_CYC = agl_pkg::AGL_RAMP_UNIT_CYC,
   parameter int REL_UNIT_CYC = agl_pkg::AGL_REL_UNIT_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sample_strobe,
   input wire logic signed [15:0] audio_in,
   input wire logic signed [15:0] preemph_in,
   input wire logic signed [15:0] modulator_in_one,
   input wire logic signed [15:0] modulator_in_two,
   output logic signed [15:0] audio_in_scaled,
   output logic signed [15:0] audio_out,
   output logic signed [15:0] modulator_output_one,
   output logic signed [15:0] modulator_output_two,
   output logic [13:0] scramble_freq_field,
   output logic [7:0] stage_order,
   output logic hard_limit_sel
);
   import agl_pkg::*;

   // Bus address phase capture
   agl_bus_type bus_state;
   logic [7:0] addr_q;
   logic write_q;
   // Parameter words as written and as applied to the signal path
   logic [15:0] regs [0:AGL_NUM_PARAMS-1];
   logic [15:0] live [0:AGL_NUM_PARAMS-1];
   // Control register; bit 15 is a self-clearing reset command
   logic [15:0] ctrl;
   // Ramp level, tick counter, agc state
   logic [8:0] ramp_lvl;
   logic [31:0] ramp_cnt;
   logic [3:0] agc_att;
   logic [31:0] rel_cnt;

   // Transfer request decode
   wire take_req = hsel && hready && htrans[1];
   wire wr_now = (bus_state == AGL_BUS_WAIT) && write_q;
   wire [5:0] word_idx = addr_q[7:2];
   wire is_param = word_idx < 6'(AGL_NUM_PARAMS);
   wire ctrl_hit = wr_now && (addr_q == AGL_OFS_CTRL);
   // Bus reset command and processing reset release
   wire bus_reset = ctrl_hit && hwdata[AGL_CTRL_BUSRST_BIT];
   wire sp_next = ctrl_hit ? hwdata[AGL_CTRL_SPRST_BIT] : ctrl[AGL_CTRL_SPRST_BIT];
   wire aux_next = ctrl_hit ? hwdata[AGL_CTRL_AUX_BIT] : ctrl[AGL_CTRL_AUX_BIT];
   wire sp_release = ctrl[AGL_CTRL_SPRST_BIT] && !sp_next && !aux_next;
   wire load_defaults = bus_reset || sp_release;
   wire tx_mode = ctrl[AGL_CTRL_TX_BIT];

   // Read data mux; unmapped words read zero
   wire [15:0] rd_word =
      is_param ? regs[word_idx[3:0]] :
      (addr_q == AGL_OFS_CTRL) ? ctrl :
      (addr_q == AGL_OFS_STATUS) ? {3'h0, agc_att, ramp_lvl} : 16'h0000;

   // Bus slave: every transfer gets one wait state so hrdata is a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= AGL_BUS_IDLE;
         addr_q <= 8'h00;
         write_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         case (bus_state)
            AGL_BUS_IDLE: begin
               // Accept address phase, stall its data phase once
               if (take_req) begin
                  bus_state <= AGL_BUS_WAIT;
                  addr_q <= haddr;
                  write_q <= hwrite;
                  hreadyout <= 1'b0;
               end
            end
            AGL_BUS_WAIT: begin
               // Finish: read data presented with hready high
               bus_state <= AGL_BUS_IDLE;
               hreadyout <= 1'b1;
               hrdata <= write_q ? 32'h0000_0000 : {16'h0000, rd_word};
            end
            default: begin
               bus_state <= AGL_BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   // Control register; the command bit never stores
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= 16'h0000;
      end else if (ctrl_hit) begin
         ctrl <= {1'b0, hwdata[14:0]};
      end
   end

   // One written word and one live word per parameter
   genvar gi;
   generate
      for (gi = 0; gi < AGL_NUM_PARAMS; gi++) begin : g_param
         wire hit = wr_now && is_param && (word_idx[3:0] == 4'(gi));
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               regs[gi] <= AGL_DEFAULTS[gi];
            end else if (load_defaults) begin
               regs[gi] <= AGL_DEFAULTS[gi];
            end else if (hit) begin
               regs[gi] <= hwdata[15:0];
            end
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               live[gi] <= AGL_DEFAULTS[gi];
            end else if (sample_strobe) begin
               live[gi] <= regs[gi];
            end
         end
      end
   endgenerate

   // Unsigned fine gain: x * (32768 - g[13:0]) / 32768
   function automatic logic signed [15:0] fine_gain(
      input logic signed [15:0] x,
      input logic [15:0] g);
      logic [16:0] k;
      logic signed [34:0] p;
      k = AGL_UNITY - {3'b000, g[AGL_FIELD_MSB:0]};
      p = x * $signed({1'b0, k});
      return p[30:15];
   endfunction

   // Limiter: hard clips at l; soft halves slope above 3l/4, then clips
   function automatic logic signed [15:0] limit(
      input logic signed [18:0] v,
      input logic [15:0] lw,
      input logic hard);
      logic [18:0] mag;
      logic [18:0] l;
      logic [18:0] knee;
      logic [18:0] m;
      mag = v[18] ? 19'(-v) : v;
      l = {5'h00, lw[AGL_FIELD_MSB:0]};
      knee = l - (l >> 2);
      m = (!hard && mag > knee) ? knee + ((mag - knee) >> 1) : mag;
      if (m > l) begin
         m = l;
      end
      return v[18] ? 16'(-m) : 16'(m);
   endfunction

   // Offset then ramp on one modulator path; 19 bits keep headroom
   function automatic logic signed [18:0] shape(
      input logic signed [15:0] g,
      input logic [15:0] ofs,
      input logic [8:0] lvl);
      logic signed [16:0] d;
      logic signed [27:0] p;
      d = 17'(g) - 17'($signed(ofs));
      p = d * $signed({1'b0, lvl});
      return p[26:8];
   endfunction

   // Ramp period of one step, from the up or down field
   wire [6:0] up_field = live[AGL_IDX_RAMP][AGL_FIELD_MSB:AGL_RAMP_UP_LSB];
   wire [6:0] dn_field = live[AGL_IDX_RAMP][AGL_RAMP_DN_MSB:0];
   wire [7:0] ramp_mult = {1'b0, tx_mode ? up_field : dn_field} + 8'h01;
   wire [31:0] step_cyc = 32'((ramp_mult * RAMP_UNIT_CYC) / AGL_RAMP_FULL);
   wire ramp_busy = tx_mode ? (ramp_lvl != 9'(AGL_RAMP_FULL)) : (ramp_lvl != 9'h000);
   wire ramp_tick = ramp_busy && (ramp_cnt + 32'h1 >= step_cyc);

   // Ramp level moves only while the transmit bit asks for a change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_lvl <= 9'h000;
         ramp_cnt <= 32'h0;
      end else if (!ramp_busy) begin
         ramp_cnt <= 32'h0;
      end else if (ramp_tick) begin
         ramp_cnt <= 32'h0;
         ramp_lvl <= tx_mode ? ramp_lvl + 9'h001 : ramp_lvl - 9'h001;
      end else begin
         ramp_cnt <= ramp_cnt + 32'h1;
      end
   end

   // Input level control decode
   wire [15:0] ord = live[AGL_IDX_ORDER];
   wire [3:0] rel_field = ord[AGL_ORD_REL_LSB+3:AGL_ORD_REL_LSB];
   wire agc_on = rel_field != 4'h0;
   wire signed [15:0] agc_ref = ord[AGL_ORD_REF_BIT] ? preemph_in : audio_in;
   wire [15:0] ref_mag = agc_ref[15] ? 16'(-agc_ref) : agc_ref;
   wire over = agc_on && sample_strobe &&
      (ref_mag > {2'b00, live[AGL_IDX_THRESH][AGL_FIELD_MSB:0]});
   // release after field times 64 ms
   wire [31:0] rel_cyc = 32'(rel_field * REL_UNIT_CYC);
   wire rel_done = (agc_att != 4'h0) && (rel_cnt + 32'h1 >= rel_cyc);

   // Attenuation steps up on each loud sample, back down after release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         agc_att <= 4'h0;
         rel_cnt <= 32'h0;
      end else if (!agc_on) begin
         agc_att <= 4'h0;
         rel_cnt <= 32'h0;
      end else if (over) begin
         rel_cnt <= 32'h0;
         agc_att <= (agc_att == 4'(AGL_AGC_STEPS)) ? agc_att : agc_att + 4'h1;
      end else if (rel_done) begin
         rel_cnt <= 32'h0;
         agc_att <= agc_att - 4'h1;
      end else if (agc_att != 4'h0) begin
         rel_cnt <= rel_cnt + 32'h1;
      end
   end

   // Input path: audio_in already carries the coarse gain
   // fine input attenuation
   wire signed [15:0] in_fine = fine_gain(audio_in, live[AGL_IDX_FIN_ONE]);
   // Level control gain (16 - steps)/16; five bits so that unity 16 survives
   wire [4:0] agc_gain = 5'h10 - {1'b0, agc_att};
   wire signed [20:0] in_agc = in_fine * $signed({1'b0, agc_gain});
   wire signed [15:0] m1_g = fine_gain(modulator_in_one, live[AGL_IDX_FOUT_ONE]);
   wire signed [15:0] m2_g = fine_gain(modulator_in_two, live[AGL_IDX_FOUT_TWO]);
   wire signed [15:0] au_g = fine_gain(preemph_in, live[AGL_IDX_FOUT_ONE]);
   wire signed [18:0] m1_s = shape(m1_g, live[AGL_IDX_OFS_ONE], ramp_lvl);
   wire signed [18:0] m2_s = shape(m2_g, live[AGL_IDX_OFS_TWO], ramp_lvl);
   wire hard = ord[AGL_ORD_HARD_BIT];
   wire signed [15:0] m1_l = limit(m1_s, live[AGL_IDX_LIMIT], hard);
   wire signed [15:0] m2_l = limit(m2_s, live[AGL_IDX_LIMIT], hard);

   // Sample outputs update together on the strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         audio_in_scaled <= 16'sh0000;
         audio_out <= 16'sh0000;
         modulator_output_one <= 16'sh0000;
         modulator_output_two <= 16'sh0000;
      end else if (sample_strobe) begin
         audio_in_scaled <= in_agc[19:4];
         audio_out <= au_g;
         modulator_output_one <= m1_l;
         modulator_output_two <= m2_l;
      end
   end

   // Configuration fields handed to the filter chain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scramble_freq_field <= 14'h0000;
         stage_order <= 8'h00;
         hard_limit_sel <= 1'b0;
      end else begin
         scramble_freq_field <= live[AGL_IDX_SCRAMBLE][AGL_FIELD_MSB:0];
         stage_order <= ord[7:0];
         hard_limit_sel <= hard;
      end
   end

   // Checks
   property p_wait_state;
      @(posedge hclk) disable iff (!hresetn)
      (take_req && bus_state == AGL_BUS_IDLE) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_wait_state: assert property (p_wait_state)
      else $error("Transfer did not complete in two cycles");
   property p_defaults;
      @(posedge hclk) disable iff (!hresetn)
      load_defaults |=> regs[AGL_IDX_LIMIT] == 16'h3fff && regs[AGL_IDX_THRESH] == 16'h0fff;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("Defaults not restored");
   property p_bus_reset_limit;
      @(posedge hclk) disable iff (!hresetn)
      bus_reset |=> regs[AGL_IDX_LIMIT] == 16'h3fff;
   endproperty
   a_bus_reset_limit: assert property (p_bus_reset_limit)
      else $error("Limiter not at maximum after bus reset");
   property p_live_hold;
      @(posedge hclk) disable iff (!hresetn)
      !sample_strobe |=> $stable(live[AGL_IDX_FOUT_ONE]);
   endproperty
   a_live_hold: assert property (p_live_hold)
      else $error("Live word changed between samples");
   property p_clip;
      @(posedge hclk) disable iff (!hresetn)
      // The sample was clipped with the limit that was live before the strobe
      $rose(sample_strobe) |=>
         (modulator_output_one <= $signed({2'b00, $past(live[AGL_IDX_LIMIT][13:0])}))
         && (modulator_output_one >= -$signed({2'b00, $past(live[AGL_IDX_LIMIT][13:0])}));
   endproperty
   a_clip: assert property (p_clip)
      else $error("Modulator output beyond limit");
   property p_ramp_dir;
      @(posedge hclk) disable iff (!hresetn)
      (tx_mode && ramp_tick) |=> ramp_lvl == $past(ramp_lvl) + 9'h001;
   endproperty
   a_ramp_dir: assert property (p_ramp_dir)
      else $error("Ramp did not rise in transmit");
   property p_ramp_idle;
      @(posedge hclk) disable iff (!hresetn)
      (!ramp_busy && $stable(tx_mode)) |=> $stable(ramp_lvl);
   endproperty
   a_ramp_idle: assert property (p_ramp_idle)
      else $error("Ramp moved while idle");
   property p_agc_off;
      @(posedge hclk) disable iff (!hresetn)
      !agc_on |=> agc_att == 4'h0;
   endproperty
   a_agc_off: assert property (p_agc_off)
      else $error("Level control active while off");
   property p_agc_step;
      @(posedge hclk) disable iff (!hresetn)
      (over && agc_att != 4'hf) |=> agc_att == $past(agc_att) + 4'h1;
   endproperty
   a_agc_step: assert property (p_agc_step)
      else $error("Gain not stepped down above threshold");
   property p_order_out;
      @(posedge hclk) disable iff (!hresetn)
      // Sampled reset keeps the release edge, where the outputs still reset, out
      hresetn |=> stage_order == $past(ord[7:0]) && hard_limit_sel == $past(hard);
   endproperty
   a_order_out: assert property (p_order_out)
      else $error("Order fields not passed on");
   c_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_now && is_param);
   c_ramp_full: cover property (@(posedge hclk) disable iff (!hresetn)
      ramp_lvl == 9'(AGL_RAMP_FULL));
   c_agc: cover property (@(posedge hclk) disable iff (!hresetn) over);
   c_sp_release: cover property (@(posedge hclk) disable iff (!hresetn) sp_release);
endmodule
`default_nettype wire

// >>> hw/agl_pkg.sv
// Package of constants for the audio gain and limiter parameter block
package agl_pkg;
   // Register byte offsets, one aligned word per parameter
   localparam int AGL_NUM_PARAMS = 12;
   localparam logic [7:0] AGL_OFS_FIRST = 8'h00;
   localparam logic [7:0] AGL_OFS_CTRL = 8'h30;
   localparam logic [7:0] AGL_OFS_STATUS = 8'h34;
   // Parameter indices
   localparam int AGL_IDX_FIN_ONE = 0;
   localparam int AGL_IDX_FIN_TWO = 1;
   localparam int AGL_IDX_FOUT_ONE = 2;
   localparam int AGL_IDX_FOUT_TWO = 3;
   localparam int AGL_IDX_OFS_ONE = 4;
   localparam int AGL_IDX_OFS_TWO = 5;
   localparam int AGL_IDX_RAMP = 6;
   localparam int AGL_IDX_LIMIT = 7;
   localparam int AGL_IDX_SCRAMBLE = 8;
   localparam int AGL_IDX_ORDER = 9;
   localparam int AGL_IDX_RESERVED = 10;
   localparam int AGL_IDX_THRESH = 11;
   // Default words, in index order
   localparam logic [15:0] AGL_DEFAULTS [0:11] = '{
      16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h3fff, 16'h1194, 16'h001b, 16'h0608, 16'h0fff};
   // Field layout
   localparam int AGL_FIELD_MSB = 13;
   localparam int AGL_RAMP_UP_LSB = 7;
   localparam int AGL_RAMP_DN_MSB = 6;
   localparam int AGL_ORD_HARD_BIT = 13;
   localparam int AGL_ORD_REF_BIT = 12;
   localparam int AGL_ORD_REL_LSB = 8;
   // Control register bits
   localparam int AGL_CTRL_TX_BIT = 1;
   localparam int AGL_CTRL_AUX_BIT = 4;
   localparam int AGL_CTRL_SPRST_BIT = 5;
   localparam int AGL_CTRL_BUSRST_BIT = 15;
   // Gain arithmetic
   localparam logic [16:0] AGL_UNITY = 17'h08000;
   localparam int AGL_RAMP_FULL = 256;
   localparam int AGL_AGC_STEPS = 15;
   // Timing
   localparam int AGL_CLK_MHZ = 200;
   localparam int AGL_RAMP_UNIT_NS = 1333000;
   localparam int AGL_RAMP_UNIT_CYC = AGL_RAMP_UNIT_NS * AGL_CLK_MHZ / 1000;
   localparam int AGL_REL_UNIT_MS = 64;
   localparam int AGL_REL_UNIT_CYC = AGL_REL_UNIT_MS * AGL_CLK_MHZ * 1000;
   // Bus slave states
   typedef enum logic [1:0] {
      AGL_BUS_IDLE = 2'b00,
      AGL_BUS_WAIT = 2'b01
   } agl_bus_type;
endpackage

// >>> tb/agl_host.sv
// Host model that programs the parameter words over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module agl_host (
   input wire logic hclk,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // Bus idle at time zero, word size only
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end

   // One single word transfer; no wait count assumed, the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      // Address released, so it shows a changed pattern
      htrans <= 2'b00;
      haddr <= ~a;
      hwdata <= w ? d : ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      // Data released, no stale value left on the bus
      hwdata <= ~hwdata;
   endtask

   // callers keep gains small, order codes distinct
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   task automatic init();
      wr(8'h28, 32'h0608);
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the audio gain and limiter parameter block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import agl_pkg::*;
   // Shortened ramp and release units keep the run brief
   localparam int RAMP_CYC = 512;
   localparam int REL_CYC = 64;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, hard_limit_sel;
   logic [7:0] haddr, stage_order;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, d;
   logic [13:0] scramble_freq_field;
   logic signed [15:0] audio_in_scaled, audio_out, mod_out_one, mod_out_two;
   logic sample_strobe = 1'b0;
   logic signed [15:0] audio_in = 16'sd0, preemph_in = 16'sd0;
   logic signed [15:0] mod_in_one = 16'sd0, mod_in_two = 16'sd0;
   int errors = 0;
   int tests_run = 0;

   always #2.5 hclk = ~hclk;

   agl_top #(.RAMP_UNIT_CYC(RAMP_CYC), .REL_UNIT_CYC(REL_CYC)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sample_strobe(sample_strobe), .audio_in(audio_in), .preemph_in(preemph_in),
      .modulator_in_one(mod_in_one), .modulator_in_two(mod_in_two),
      .audio_in_scaled(audio_in_scaled), .audio_out(audio_out),
      .modulator_output_one(mod_out_one), .modulator_output_two(mod_out_two),
      .scramble_freq_field(scramble_freq_field), .stage_order(stage_order),
      .hard_limit_sel(hard_limit_sel));

   // Single master, its hready is the slave's hreadyout
   agl_host i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      i_host.rd(a, d);
      chk(what, exp, d);
   endtask

   // Ramp level sits in the low status bits
   task automatic lvl_chk(input string what, input logic mid, input logic [8:0] exp);
      i_host.rd(8'h34, d);
      if (mid) chk(what, 32'h1, {31'h0, (d[8:0] > 9'd0) && (d[8:0] < 9'd256)});
      else chk(what, {23'h0, exp}, {23'h0, d[8:0]});
   endtask

   // Sample pulses; outputs are looked at once the last pulse edge has landed
   task automatic strobe(input int n);
      repeat (n) begin
         @(posedge hclk) sample_strobe <= 1'b1;
         @(posedge hclk) sample_strobe <= 1'b0;
      end
      // Configuration outputs follow the live words one edge later
      @(posedge hclk);
      #1;
   endtask

   task automatic t_defaults();
      i_host.init();
      for (int i = 0; i < AGL_NUM_PARAMS; i++) begin
         rd_chk("default word", 8'(4 * i), {16'h0, AGL_DEFAULTS[i]});
      end
      i_host.wr(8'h3c, 32'h1234);
      rd_chk("unmapped word", 8'h3c, 32'h0);
      chk("response", 32'h0, 32'(hresp));
      $display("test defaults done");
   endtask

   task automatic t_order();
      i_host.wr(8'h24, 32'h204b);
      i_host.wr(8'h20, 32'h0800);
      strobe(1);
      chk("stage order", 32'h4b, 32'(stage_order));
      chk("hard limiter", 32'h1, 32'(hard_limit_sel));
      chk("scramble field", 32'h0800, 32'(scramble_freq_field));
      i_host.wr(8'h24, 32'h001b);
      strobe(1);
      chk("soft limiter", 32'h0, 32'(hard_limit_sel));
      chk("stage order", 32'h1b, 32'(stage_order));
      $display("test order done");
   endtask

   task automatic t_gain();
      @(posedge hclk) audio_in <= 16'sd16000;
      preemph_in <= 16'sd8000;
      i_host.wr(8'h00, 32'h9000);
      i_host.wr(8'h08, 32'h2000);
      strobe(2);
      chk("scaled input", 32'd14000, 32'(audio_in_scaled));
      chk("audio output", 32'd6000, 32'(audio_out));
      i_host.wr(8'h00, 32'h8000);
      i_host.wr(8'h08, 32'h0000);
      $display("test gain done");
   endtask

   task automatic t_ramp();
      @(posedge hclk) mod_in_one <= 16'sd1000;
      mod_in_two <= -16'sd700;
      i_host.wr(8'h10, 32'h0064);
      i_host.wr(8'h18, 32'h0001);
      i_host.wr(8'h30, 32'h0002);
      repeat (100) @(posedge hclk);
      lvl_chk("ramp rising", 1'b1, 9'd0);
      repeat (500) @(posedge hclk);
      lvl_chk("ramp full", 1'b0, 9'd256);
      strobe(2);
      chk("offset output", 32'd900, 32'(mod_out_one));
      chk("plain output", 32'hfffffd44, 32'(mod_out_two));
      // Limit 768: soft knee at 576, slope halved above it
      i_host.wr(8'h1c, 32'h0300);
      strobe(2);
      chk("soft clip", 32'd738, 32'(mod_out_one));
      chk("soft clip two", 32'hfffffd82, 32'(mod_out_two));
      i_host.wr(8'h24, 32'h201b);
      strobe(2);
      chk("hard clip", 32'd768, 32'(mod_out_one));
      chk("hard clip two", 32'hfffffd44, 32'(mod_out_two));
      i_host.wr(8'h30, 32'h0000);
      repeat (600) @(posedge hclk);
      lvl_chk("ramp falling", 1'b1, 9'd0);
      repeat (600) @(posedge hclk);
      lvl_chk("ramp zero", 1'b0, 9'd0);
      strobe(1);
      chk("silent output", 32'd0, 32'(mod_out_one));
      $display("test ramp done");
   endtask

   task automatic t_resets();
      i_host.wr(8'h1c, 32'h0100);
      rd_chk("limit word", 8'h1c, 32'h0100);
      i_host.wr(8'h2c, 32'h0040);
      i_host.wr(8'h30, 32'h8000);
      rd_chk("limit after bus reset", 8'h1c, 32'h3fff);
      rd_chk("threshold after bus reset", 8'h2c, 32'h0fff);
      i_host.wr(8'h24, 32'h004b);
      i_host.wr(8'h30, 32'h0030);
      i_host.wr(8'h30, 32'h0010);
      rd_chk("order kept", 8'h24, 32'h004b);
      i_host.wr(8'h30, 32'h0020);
      i_host.wr(8'h30, 32'h0000);
      rd_chk("order restored", 8'h24, 32'h001b);
      $display("test resets done");
   endtask

   task automatic t_level();
      i_host.wr(8'h2c, 32'h0010);
      i_host.wr(8'h24, 32'h011b);
      strobe(20);
      i_host.rd(8'h34, d);
      chk("level steps", 32'd15, {28'h0, d[12:9]});
      strobe(1);
      chk("level input", 32'd1000, 32'(audio_in_scaled));
      @(posedge hclk) audio_in <= 16'sd0;
      strobe(1);
      repeat (1100) @(posedge hclk);
      i_host.rd(8'h34, d);
      chk("level released", 32'd0, {28'h0, d[12:9]});
      // Silent audio input, loud emphasis output as reference
      i_host.wr(8'h24, 32'h111b);
      strobe(3);
      i_host.rd(8'h34, d);
      chk("level from emphasis", 32'd2, {28'h0, d[12:9]});
      $display("test level done");
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      #100000;
      errors++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_defaults();
      t_order();
      t_gain();
      t_ramp();
      t_resets();
      t_level();
      complete_run();
   end
endmodule
`default_nettype wire
